// file: hdl/ulrr_phy.sv
// phy-side ulpi register access and status byte sender
`timescale 1ns/1ps
module ulrr_phy (
	// clock and reset
	input  wire logic                  clk_sys_i,
	input  wire logic                  nrst_i,
	// ulpi pins
	input  wire logic [7:0]            ulpi_data_i,
	output logic      [7:0]            ulpi_data_o,
	output logic                       ulpi_data_oe_n_o,
	output logic                       ulpi_dir_o,
	output logic                       ulpi_nxt_o,
	input  wire logic                  ulpi_stp_i,
	// analog levels from pins
	input  wire logic                  dp_i,
	input  wire logic                  dm_i,
	input  wire ulrr_pkg::ulrr_cmp_t   cmp_i,
	// state from the rest of the phy
	input  wire logic                  rx_active_i,
	input  wire logic                  rx_error_i,
	input  wire logic                  host_disc_i,
	input  wire logic                  rx_busy_i,
	input  wire logic                  rx_nxt_i,
	input  wire logic                  tx_busy_i,
	input  wire logic                  alt_int_i,
	input  wire logic                  mode_exit_i,
	// register array port
	output ulrr_pkg::ulrr_reg_wr_t     reg_wr_o,
	output logic      [7:0]            reg_rd_addr_o,
	input  wire logic [7:0]            reg_rd_data_i
);
	import ulrr_pkg::*;

	typedef enum logic [3:0] {
		S_START, S_IDLE, S_WNXT, S_WDAT, S_WEXA, S_WSTP, S_RNXT, S_REXA,
		S_RTURN, S_RDRV, S_STURN, S_SDRV, S_WACC, S_RACC
	} ulrr_st_t;

	ulrr_st_t     st_r;
	ulrr_st_t     st_nxt;
	logic [7:0]   cmd_r;
	logic [7:0]   cmd_nxt;
	logic [7:0]   adr_r;
	logic [7:0]   adr_nxt;
	logic [7:0]   wdat_r;
	logic [7:0]   wdat_nxt;
	logic [7:0]   dat_r;
	logic [7:0]   dat_nxt;
	logic         oe_n_r;
	logic         oe_n_nxt;
	logic         dir_r;
	logic         dir_nxt;
	logic         nxt_r;
	logic         nxt_nxt;
	ulrr_reg_wr_t wr_r;
	ulrr_reg_wr_t wr_nxt;
	logic [5:0]   lvl_prev_r;
	logic [5:0]   lvl_prev_nxt;
	logic         pend_r;
	logic         pend_nxt;
	logic         tx_stp_r;
	logic         tx_stp_nxt;
	logic [5:0]   lvl_s;
	logic [5:0]   pin_raw;
	ulrr_rxcmd_t  rxcmd;
	logic         chg;

	assign pin_raw = {dm_i, dp_i, cmp_i};

	ulrr_sync #(
		.W(6)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.nrst_i   (nrst_i),
		.d_i      (pin_raw),
		.q_o      (lvl_s)
	);

	// status byte assembly
	always_comb begin
		rxcmd.line = {lvl_s[5], lvl_s[4]};
		if (lvl_s[1])
			rxcmd.vbus = ULRR_VB_VVLD;
		else if (lvl_s[2])
			rxcmd.vbus = ULRR_VB_SVLD;
		else if (lvl_s[3])
			rxcmd.vbus = ULRR_VB_END;
		else
			rxcmd.vbus = ULRR_VB_SES;
		if (host_disc_i)
			rxcmd.rx_ev = ULRR_RX_DISC;
		else if (rx_active_i && rx_error_i)
			rxcmd.rx_ev = ULRR_RX_ERR;
		else if (rx_active_i)
			rxcmd.rx_ev = ULRR_RX_ACT;
		else
			rxcmd.rx_ev = ULRR_RX_NONE;
		rxcmd.id = lvl_s[0];
		rxcmd.alt_int = alt_int_i;
	end

	assign chg = (lvl_s != lvl_prev_r);

	always_comb begin
		st_nxt       = st_r;
		cmd_nxt      = cmd_r;
		adr_nxt      = adr_r;
		wdat_nxt     = wdat_r;
		dat_nxt      = ULRR_IDLE;
		oe_n_nxt     = 1'b1;
		dir_nxt      = dir_r;
		nxt_nxt      = 1'b0;
		wr_nxt       = '0;
		wr_nxt.addr  = adr_r;
		wr_nxt.data  = wdat_r;
		lvl_prev_nxt = lvl_s;
		pend_nxt     = pend_r | chg;
		tx_stp_nxt   = tx_stp_r | (tx_busy_i && ulpi_stp_i);
		case (st_r)
			S_START: begin
				dir_nxt  = 1'b0;
				pend_nxt = 1'b1;
				st_nxt   = S_IDLE;
			end
			S_IDLE: begin
				dir_nxt = 1'b0;
				if (mode_exit_i && ulpi_stp_i)
					pend_nxt = 1'b1;
				if (ulpi_data_i[7:ULRR_CMD_POS] == ULRR_CMD_WR ||
				    ulpi_data_i[7:ULRR_CMD_POS] == ULRR_CMD_RD) begin
					cmd_nxt = ulpi_data_i;
					adr_nxt = {2'h0, ulpi_data_i[5:0]};
					st_nxt  = ulpi_data_i[ULRR_CMD_POS] ? S_RNXT : S_WNXT;
				end else if (rx_busy_i && !rx_nxt_i) begin
					dir_nxt  = 1'b1;
					pend_nxt = 1'b1;
					st_nxt   = S_STURN;
				end else if (pend_r && (!tx_busy_i || tx_stp_r)) begin
					dir_nxt    = 1'b1;
					tx_stp_nxt = tx_busy_i && ulpi_stp_i;
					st_nxt     = S_STURN;
				end
			end
			S_WNXT: begin
				nxt_nxt = 1'b1;
				st_nxt  = S_WACC;
			end
			S_WACC: begin
				nxt_nxt = 1'b1;
				st_nxt  = (cmd_r[5:0] == ULRR_ADR_EXT) ? S_WEXA : S_WDAT;
			end
			S_WEXA: begin
				adr_nxt = ulpi_data_i;
				nxt_nxt = 1'b1;
				st_nxt  = S_WDAT;
			end
			S_WDAT: begin
				wdat_nxt = ulpi_data_i;
				nxt_nxt  = 1'b1;
				st_nxt   = S_WSTP;
			end
			S_WSTP: begin
				if (ulpi_stp_i) begin
					wr_nxt.we = 1'b1;
					st_nxt    = S_IDLE;
				end
			end
			S_RNXT: begin
				nxt_nxt = 1'b1;
				st_nxt  = S_RACC;
			end
			S_RACC: begin
				// escape address asks for extended byte
				if (cmd_r[5:0] == ULRR_ADR_EXT) begin
					nxt_nxt = 1'b1;
					st_nxt  = S_REXA;
				end else begin
					dir_nxt = 1'b1;
					st_nxt  = S_RTURN;
				end
			end
			S_REXA: begin
				adr_nxt = ulpi_data_i;
				dir_nxt = 1'b1;
				st_nxt  = S_RTURN;
			end
			S_RTURN: begin
				dat_nxt  = reg_rd_data_i;
				oe_n_nxt = 1'b0;
				st_nxt   = S_RDRV;
			end
			S_RDRV: begin
				dir_nxt = 1'b0;
				st_nxt  = S_IDLE;
			end
			S_STURN: begin
				dat_nxt  = rxcmd;
				oe_n_nxt = 1'b0;
				pend_nxt = chg;
				st_nxt   = S_SDRV;
			end
			S_SDRV: begin
				if (rx_busy_i && !rx_nxt_i) begin
					dat_nxt  = rxcmd;
					oe_n_nxt = 1'b0;
				end else if (!rx_busy_i) begin
					dir_nxt = 1'b0;
					st_nxt  = S_IDLE;
				end else begin
					oe_n_nxt = 1'b0;
					nxt_nxt  = 1'b1;
				end
			end
			default: begin
				st_nxt = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r       <= S_START;
			cmd_r      <= ULRR_DAT_RST;
			adr_r      <= ULRR_DAT_RST;
			wdat_r     <= ULRR_DAT_RST;
			dat_r      <= ULRR_DAT_RST;
			oe_n_r     <= 1'b1;
			dir_r      <= 1'b1;
			nxt_r      <= 1'b0;
			wr_r       <= '0;
			lvl_prev_r <= '0;
			pend_r     <= 1'b0;
			tx_stp_r   <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			cmd_r      <= cmd_nxt;
			adr_r      <= adr_nxt;
			wdat_r     <= wdat_nxt;
			dat_r      <= dat_nxt;
			oe_n_r     <= oe_n_nxt;
			dir_r      <= dir_nxt;
			nxt_r      <= nxt_nxt;
			wr_r       <= wr_nxt;
			lvl_prev_r <= lvl_prev_nxt;
			pend_r     <= pend_nxt;
			tx_stp_r   <= tx_stp_nxt;
		end
	end

	assign ulpi_data_o      = dat_r;
	assign ulpi_data_oe_n_o = oe_n_r;
	assign ulpi_dir_o       = dir_r;
	assign ulpi_nxt_o       = nxt_r;
	assign reg_wr_o         = wr_r;
	assign reg_rd_addr_o    = adr_r;

	// direction low while a write runs
	a_wr_dir_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(st_r inside {S_WACC, S_WEXA, S_WDAT, S_WSTP}) |-> !ulpi_dir_o) else $error("dir high in write");

	sequence s_wr_cmd;
		st_r == S_IDLE && ulpi_data_i[7:6] == ULRR_CMD_WR && ulpi_data_i[5:0] != ULRR_ADR_EXT;
	endsequence

	// next high for three clocks, starting two clocks after write command
	a_wr_nxt_time: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		s_wr_cmd |=> !ulpi_nxt_o ##1 ulpi_nxt_o [*3] ##1 !ulpi_nxt_o) else $error("write next late");

	a_wr_commit: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		reg_wr_o.we |-> $past(ulpi_stp_i) && $past(st_r) == S_WSTP) else $error("early commit");

	// store one edge after stop seen
	a_wr_stp_store: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(st_r == S_WSTP && ulpi_stp_i) |=> reg_wr_o.we ##1 !reg_wr_o.we) else $error("store miss");

	sequence s_rd_cmd;
		st_r == S_IDLE && ulpi_data_i[7:6] == ULRR_CMD_RD && ulpi_data_i[5:0] != ULRR_ADR_EXT;
	endsequence

	a_rd_dir_up: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		s_rd_cmd |=> ##1 (ulpi_nxt_o && !ulpi_dir_o) ##1 (ulpi_dir_o && !ulpi_nxt_o))
		else $error("read dir timing");

	a_rd_drive: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		s_rd_cmd |=> ##3 (!ulpi_data_oe_n_o && ulpi_dir_o)) else $error("read value late");

	a_rd_release: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(st_r == S_RDRV) |=> !ulpi_dir_o && ulpi_data_oe_n_o) else $error("read release late");

	// change is reported within a bound
	a_chg_report: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(chg && !pend_r && st_r == S_IDLE && !tx_busy_i && !rx_busy_i && !ulpi_data_i[7])
		##1 (!tx_busy_i && !ulpi_data_i[7])
		|=> ##1 (ulpi_dir_o && !ulpi_data_oe_n_o && !ulpi_nxt_o)) else $error("status not sent");
endmodule

// file: hdl/ulrr_pkg.sv
// package: constants and types for the ulpi register access and status byte logic
package ulrr_pkg;
	localparam logic [1:0] ULRR_CMD_WR   = 2'h2;
	localparam logic [1:0] ULRR_CMD_RD   = 2'h3;
	localparam logic [5:0] ULRR_ADR_EXT  = 6'h2F;
	localparam logic [7:0] ULRR_IDLE     = 8'h00;
	localparam int         ULRR_CMD_POS  = 6;
	localparam logic [7:0] ULRR_DAT_RST  = 8'h00;
	localparam logic [1:0] ULRR_VB_END   = 2'h0;
	localparam logic [1:0] ULRR_VB_SES   = 2'h1;
	localparam logic [1:0] ULRR_VB_SVLD  = 2'h2;
	localparam logic [1:0] ULRR_VB_VVLD  = 2'h3;
	localparam logic [1:0] ULRR_RX_NONE  = 2'h0;
	localparam logic [1:0] ULRR_RX_ACT   = 2'h1;
	localparam logic [1:0] ULRR_RX_ERR   = 2'h3;
	localparam logic [1:0] ULRR_RX_DISC  = 2'h2;

	typedef struct packed {
		logic       alt_int;
		logic       id;
		logic [1:0] rx_ev;
		logic [1:0] vbus;
		logic [1:0] line;
	} ulrr_rxcmd_t;

	typedef struct packed {
		logic sess_end;
		logic sess_vld;
		logic vbus_vld;
		logic id;
	} ulrr_cmp_t;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} ulrr_reg_wr_t;
endpackage

// file: hdl/ulrr_sync.sv
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module ulrr_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         nrst_i,
	// levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] s2_nxt;

	always_comb begin
		s1_nxt = d_i;
		s2_nxt = s1_r;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	assign q_o = s2_r;
endmodule

// file: sim/ulrr_link.sv
// link controller model that drives the ulpi bus towards the phy
`timescale 1ns/1ps
module ulrr_link (
	// clock
	input  wire logic       clk_sys_i,
	// ulpi pins seen from the link
	input  wire logic       dir_i,
	input  wire logic       nxt_i,
	input  wire logic [7:0] bus_i,
	output logic      [7:0] data_o,
	output logic            stp_o
);
	import ulrr_pkg::*;
	initial begin
		data_o = ULRR_IDLE;
		stp_o  = 1'h0;
	end
	// wait for dir or nxt to reach a level, then step off the edge
	task automatic wait_for(input logic use_dir, input logic lvl, output logic ok);
		ok = 1'h0;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge clk_sys_i);
			ok = (use_dir ? dir_i : nxt_i) == lvl;
		end
		#1;
	endtask
	task automatic stop_pulse();
		stp_o = 1'h1;
		@(posedge clk_sys_i);
		#1;
		stp_o = 1'h0;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic dh,
		output logic ok);
		logic ext;
		ext = a[7:6] != 2'h0 || a[5:0] == ULRR_ADR_EXT;
		wait_for(1'h1, 1'h0, ok);
		data_o = {ULRR_CMD_WR, ext ? ULRR_ADR_EXT : a[5:0]};
		wait_for(1'h0, 1'h1, ok);
		dh = dir_i;
		if (ext) begin
			data_o = a;
			wait_for(1'h0, 1'h1, ok);
		end
		data_o = d;
		@(posedge clk_sys_i);
		#1;
		dh = dh | dir_i;
		data_o = ULRR_IDLE;
		stop_pulse();
		dh = dh | dir_i;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v, output logic bk,
		output logic ok);
		logic ext;
		ext = a[7:6] != 2'h0 || a[5:0] == ULRR_ADR_EXT;
		wait_for(1'h1, 1'h0, ok);
		data_o = {ULRR_CMD_RD, ext ? ULRR_ADR_EXT : a[5:0]};
		wait_for(1'h0, 1'h1, ok);
		if (ext) begin
			data_o = a;
			@(posedge clk_sys_i);
			#1;
		end
		data_o = ULRR_IDLE;
		wait_for(1'h1, 1'h1, ok);
		@(posedge clk_sys_i);
		v = bus_i;
		@(posedge clk_sys_i);
		bk = !dir_i;
		#1;
	endtask
endmodule

// file: sim/ulrr_phy_tb.sv
// self-checking testbench for the phy register access and status byte logic
`timescale 1ns/1ps
module ulrr_phy_tb;
	import ulrr_pkg::*;
	logic         clk_sys_i = 1'h0;
	logic         nrst_i = 1'h0;
	logic   [7:0] bus, ulpi_data_o, link_d, reg_rd_addr_o, rx_last, lfsr = 8'h18;
	logic   [7:0] turn = 8'h5A;
	logic         ulpi_data_oe_n_o, ulpi_dir_o, ulpi_nxt_o, stp;
	logic         dp_i = 1'h0, dm_i = 1'h0, rx_active_i = 1'h0, rx_error_i = 1'h0;
	logic         host_disc_i = 1'h0, rx_busy_i = 1'h0, tx_busy_i = 1'h0;
	logic         alt_int_i = 1'h0, mode_exit_i = 1'h0, rx_nxt_i = 1'h0;
	ulrr_cmp_t    cmp_i = '0;
	ulrr_reg_wr_t reg_wr_o, wr_last;
	int           err_total = 0, compares = 0, rx_cnt = 0, we_cnt = 0, early_we = 0;

	always #50 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) turn <= ~turn;
	assign bus = !ulpi_data_oe_n_o ? ulpi_data_o : (ulpi_dir_o ? turn : link_d);

	ulrr_phy DUT (.clk_sys_i, .nrst_i, .ulpi_data_i(bus), .ulpi_data_o, .ulpi_data_oe_n_o,
		.ulpi_dir_o, .ulpi_nxt_o, .ulpi_stp_i(stp), .dp_i, .dm_i, .cmp_i, .rx_active_i,
		.rx_error_i, .host_disc_i, .rx_busy_i, .rx_nxt_i, .tx_busy_i, .alt_int_i,
		.mode_exit_i, .reg_wr_o, .reg_rd_addr_o, .reg_rd_data_i(reg_rd_addr_o ^ 8'hA5));
	ulrr_link link (.clk_sys_i, .dir_i(ulpi_dir_o), .nxt_i(ulpi_nxt_o), .bus_i(bus),
		.data_o(link_d), .stp_o(stp));

	always @(posedge clk_sys_i) begin
		if (ulpi_dir_o && !ulpi_data_oe_n_o && !ulpi_nxt_o) begin
			rx_cnt++;
			rx_last = bus;
		end
		if (reg_wr_o.we === 1'h1) begin
			we_cnt++;
			wr_last = reg_wr_o;
			if (stp) early_we++;
		end
	end

	function automatic logic [7:0] exp_rx();
		ulrr_rxcmd_t r;
		r.line = {dm_i, dp_i};
		r.vbus = cmp_i.vbus_vld ? ULRR_VB_VVLD : cmp_i.sess_vld ? ULRR_VB_SVLD :
			cmp_i.sess_end ? ULRR_VB_END : ULRR_VB_SES;
		r.rx_ev = host_disc_i ? ULRR_RX_DISC : !rx_active_i ? ULRR_RX_NONE :
			rx_error_i ? ULRR_RX_ERR : ULRR_RX_ACT;
		r.id = cmp_i.id;
		r.alt_int = alt_int_i;
		return r;
	endfunction
	task automatic rnd(output logic [7:0] v);
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		v = lfsr;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic end_sim();
		if (err_total == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wait_up(input logic sel_we, input int n0, output logic ok);
		ok = 1'h0;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge clk_sys_i);
			ok = (sel_we ? we_cnt : rx_cnt) > n0;
		end
		#1;
	endtask

	initial begin
		#5000000;
		err_total++;
		end_sim();
	end

	initial begin
		logic [7:0] a, d, v;
		logic       ok, dh, bk;
		int         n0;
		repeat (5) @(posedge clk_sys_i);
		#1;
		nrst_i = 1'h1;
		wait_up(1'h0, 0, ok);
		check(ok, 1'h1, "start-up status");
		for (int i = 0; i < 12; i++) begin
			link.wait_for(1'h1, 1'h0, ok);
			rnd(a);
			rnd(d);
			n0 = rx_cnt;
			{dm_i, cmp_i.sess_end, cmp_i.sess_vld, cmp_i.vbus_vld} = a[3:0];
			{alt_int_i, rx_active_i, rx_error_i, host_disc_i} = d[3:0];
			if (i[0]) cmp_i.id = ~cmp_i.id;
			else dp_i = ~dp_i;
			wait_up(1'h0, n0, ok);
			check(ok, 1'h1, "no status on change");
			link.wait_for(1'h1, 1'h0, ok);
			check(rx_last, exp_rx(), "status byte");
		end
		{alt_int_i, rx_active_i, rx_error_i, host_disc_i} = 4'h0;
		for (int i = 0; i < 8; i++) begin
			rnd(a);
			rnd(d);
			if (i > 2) a[7:6] = 2'h0;
			if (i == 0) a = {2'h0, ULRR_ADR_EXT};
			n0 = we_cnt;
			link.wr_reg(a, d, dh, ok);
			check(ok, 1'h1, "write handshake");
			check(dh, 1'h0, "dir during write");
			wait_up(1'h1, n0, ok);
			check(ok, 1'h1, "no commit");
			check(wr_last.addr, a, "write address");
			check(wr_last.data, d, "write data");
			link.rd_reg(a, v, bk, ok);
			check(ok, 1'h1, "read handshake");
			check(v, a ^ 8'hA5, "read value");
			check(bk, 1'h1, "bus not returned");
		end
		check(early_we[7:0], 8'h00, "commit under stop");
		rx_busy_i = 1'h1;
		for (int k = 0; k < 3; k++) begin
			{rx_active_i, rx_error_i, host_disc_i} = k == 0 ? 3'h4 : k == 1 ? 3'h6 : 3'h1;
			wait_up(1'h0, rx_cnt + 2, ok);
			check(ok, 1'h1, "no receive status");
			check(rx_last, exp_rx(), "receive status");
		end
		rx_nxt_i = 1'h1;
		repeat (2) @(posedge clk_sys_i);
		#1;
		n0 = rx_cnt;
		repeat (4) @(posedge clk_sys_i);
		#1;
		check(rx_cnt[7:0], n0[7:0], "status while next high");
		check(ulpi_nxt_o, 1'h1, "next not raised in receive");
		rx_nxt_i = 1'h0;
		{rx_busy_i, rx_active_i, rx_error_i, host_disc_i} = 4'h0;
		link.wait_for(1'h1, 1'h0, ok);
		tx_busy_i = 1'h1;
		n0 = rx_cnt;
		dp_i = ~dp_i;
		repeat (8) @(posedge clk_sys_i);
		#1;
		check(rx_cnt[7:0], n0[7:0], "status during transmit");
		link.stop_pulse();
		wait_up(1'h0, n0, ok);
		check(ok, 1'h1, "no status after stop");
		tx_busy_i = 1'h0;
		link.wait_for(1'h1, 1'h0, ok);
		mode_exit_i = 1'h1;
		n0 = rx_cnt;
		link.stop_pulse();
		wait_up(1'h0, n0, ok);
		check(ok, 1'h1, "no status on mode exit");
		mode_exit_i = 1'h0;
		end_sim();
	end
endmodule
